//--- rtl/nv_data_pkg.sv
package nv_data_pkg;
  // Register offsets on the plain register port
  localparam logic [7:0] OFF_DATA = 8'h9a;
  localparam logic [7:0] OFF_ADDR = 8'h9b;
  localparam logic [7:0] OFF_CONTROL = 8'h9c;
  localparam logic [7:0] OFF_UNLOCK = 8'h9d;
  localparam logic [7:0] OFF_FLAGS = 8'h9e;
  // Control register fields
  localparam int BIT_RD = 0;
  localparam int BIT_WR = 1;
  localparam int BIT_ALLOW = 2;
  localparam int BIT_ABORT = 3;
  // Flag register field
  localparam int BIT_DONE = 0;
  // Unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // Idle cycles between the two key writes and before the start write, exact
  localparam logic [1:0] UNLOCK_GAP = 2'h1;
  // Timing, clock rate and derived counts
  localparam int CLK_MHZ = 200;
  localparam int PWRUP_MS = 72;
  localparam longint PWRUP_CYCLES = longint'(PWRUP_MS) * 1000 * CLK_MHZ;
  localparam int WRITE_US = 4;
  localparam int WRITE_CYCLES = WRITE_US * CLK_MHZ;
endpackage : nv_data_pkg

//--- rtl/nv_write_timer.sv
`timescale 1ns/100ps
// Self-timed erase then program phases of one byte write
module nv_write_timer #(
  parameter int CYCLES = 800
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic start,
  output logic busy,
  output logic erase_phase,
  output logic done
);
  logic [31:0] count;

  // Countdown; first half erases, second half programs
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      count <= 32'h0;
      busy <= 1'b0;
      done <= 1'b0;
      erase_phase <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && !busy)
      begin
        count <= 32'(CYCLES - 1);
        busy <= 1'b1;
        erase_phase <= 1'b1;
      end
      else if (busy)
      begin
        count <= count - 32'h1;
        if (count == 32'(CYCLES / 2))
          erase_phase <= 1'b0;
        if (count == 32'h0)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule : nv_write_timer

//--- rtl/nv_data_ctrl.sv
// Decided for this implementation: the strobed register port.
`timescale 1ns/100ps
module nv_data_ctrl #(
  parameter int DEPTH = 256,
  parameter longint PWRUP_CYCLES = nv_data_pkg::PWRUP_CYCLES,
  parameter int WRITE_CYCLES = nv_data_pkg::WRITE_CYCLES
) (
  // Clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic por_n,
  input wire logic pwrup_timer_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Status
  output logic write_busy,
  output logic write_done_flag
);
  logic [7:0] mem [DEPTH];
  logic [7:0] byte_address_reg;
  logic [7:0] byte_data_reg;
  logic read_start;
  logic write_start;
  logic write_allow;
  logic write_abort_flag;
  logic [1:0] unlock_state;
  logic [1:0] gap;
  logic [39:0] pwrup_count;
  logic pwrup_hold;
  logic start_write;
  logic tmr_busy;
  logic tmr_erase;
  logic tmr_done;
  logic wr_ctrl;
  logic wr_unlock;
  logic in_range;

  assign wr_ctrl = reg_wr && reg_addr == nv_data_pkg::OFF_CONTROL;
  assign wr_unlock = reg_wr && reg_addr == nv_data_pkg::OFF_UNLOCK;
  // Address outside a small array is decoded, so it hits nothing
  assign in_range = 9'(byte_address_reg) < 9'(DEPTH);
  // Start only with allow, no power-up hold, exact unlock timing
  assign start_write = wr_ctrl && reg_wdata[nv_data_pkg::BIT_WR] && !write_start
    && write_allow && !pwrup_hold
    && unlock_state == 2'h2 && gap == nv_data_pkg::UNLOCK_GAP;

  // Power-up delay counted from power-on reset only
  always_ff @(posedge clk)
  begin
    if (!por_n)
    begin
      pwrup_count <= 40'h0;
      pwrup_hold <= 1'b1;
    end
    else if (pwrup_hold)
    begin
      pwrup_count <= pwrup_count + 40'h1;
      if (!pwrup_timer_en || pwrup_count >= 40'(PWRUP_CYCLES - 1))
        pwrup_hold <= 1'b0;
    end
  end

  // Unlock sequence tracker; any other register write breaks it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      unlock_state <= 2'h0;
      gap <= 2'h0;
    end
    else if (wr_unlock && reg_wdata == nv_data_pkg::KEY_FIRST)
    begin
      unlock_state <= 2'h1;
      gap <= 2'h0;
    end
    else if (wr_unlock && reg_wdata == nv_data_pkg::KEY_SECOND && unlock_state == 2'h1
      && gap == nv_data_pkg::UNLOCK_GAP)
    begin
      unlock_state <= 2'h2;
      gap <= 2'h0;
    end
    else if (reg_wr || unlock_state == 2'h0 || gap == 2'h3)
    begin
      unlock_state <= 2'h0;
      gap <= 2'h0;
    end
    else
      gap <= gap + 2'h1;
  end

  // Write allow: cleared at power-up, never by hardware
  always_ff @(posedge clk)
  begin
    if (!por_n)
      write_allow <= 1'b0;
    else if (wr_ctrl)
      write_allow <= reg_wdata[nv_data_pkg::BIT_ALLOW];
  end

  // Abort flag: a reset during a write marks it; software may write it
  always_ff @(posedge clk)
  begin
    if (!por_n)
      write_abort_flag <= 1'b0;
    else if (!rst_n)
    begin
      if (write_start)
        write_abort_flag <= 1'b1;
    end
    else if (wr_ctrl)
      write_abort_flag <= reg_wdata[nv_data_pkg::BIT_ABORT];
  end

  // Start bits: software sets only, hardware clears
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      read_start <= 1'b0;
      write_start <= 1'b0;
    end
    else
    begin
      read_start <= 1'b0;
      if (start_write)
        write_start <= 1'b1;
      else if (tmr_done)
        write_start <= 1'b0;
      if (wr_ctrl && reg_wdata[nv_data_pkg::BIT_RD] && !write_start)
        read_start <= 1'b1;
    end
  end

  // Done flag: set wins over software clear
  always_ff @(posedge clk)
  begin
    if (!por_n)
      write_done_flag <= 1'b0;
    else if (tmr_done)
      write_done_flag <= 1'b1;
    else if (reg_wr && reg_addr == nv_data_pkg::OFF_FLAGS)
      write_done_flag <= reg_wdata[nv_data_pkg::BIT_DONE];
  end

  // Address and data survive non-power resets for a rewrite
  always_ff @(posedge clk)
  begin
    if (!por_n)
    begin
      byte_address_reg <= 8'h00;
      byte_data_reg <= 8'h00;
    end
    else if (rst_n)
    begin
      if (reg_wr && reg_addr == nv_data_pkg::OFF_ADDR && !write_start)
        byte_address_reg <= reg_wdata;
      if (reg_wr && reg_addr == nv_data_pkg::OFF_DATA && !write_start)
        byte_data_reg <= reg_wdata;
      else if (wr_ctrl && reg_wdata[nv_data_pkg::BIT_RD] && !write_start)
        byte_data_reg <= in_range ? mem[byte_address_reg] : 8'h00;
    end
  end

  // Array: erased phase then programmed byte at timer end
  always_ff @(posedge clk)
  begin
    if (rst_n && write_start && in_range)
    begin
      if (tmr_erase)
        mem[byte_address_reg] <= 8'hff;
      else if (tmr_done)
        mem[byte_address_reg] <= byte_data_reg;
    end
  end

  // Self-timed write; a reset cuts it short
  nv_write_timer #(
    .CYCLES(WRITE_CYCLES)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .start(start_write),
    .busy(tmr_busy),
    .erase_phase(tmr_erase),
    .done(tmr_done)
  );

  // Read data, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      write_busy <= 1'b0;
    end
    else
    begin
      write_busy <= tmr_busy;
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        case (reg_addr)
          nv_data_pkg::OFF_DATA: reg_rdata <= byte_data_reg;
          nv_data_pkg::OFF_ADDR: reg_rdata <= byte_address_reg;
          nv_data_pkg::OFF_CONTROL: reg_rdata <= {4'h0, write_abort_flag, write_allow,
            write_start, read_start};
          nv_data_pkg::OFF_UNLOCK: reg_rdata <= 8'h00;
          nv_data_pkg::OFF_FLAGS: reg_rdata <= {7'h00, write_done_flag};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // Unlock steps; the single idle cycle between keys is part of the key
  sequence s_first_key;
    wr_unlock && reg_wdata == nv_data_pkg::KEY_FIRST;
  endsequence

  sequence s_second_key;
    wr_unlock && reg_wdata == nv_data_pkg::KEY_SECOND;
  endsequence

  sequence s_gap_cycle;
    !reg_wr;
  endsequence

  sequence s_start_request;
    wr_ctrl && reg_wdata[nv_data_pkg::BIT_WR] && write_allow && !pwrup_hold && !write_start;
  endsequence

  sequence s_exact_unlock;
    s_first_key ##1 s_gap_cycle ##1 s_second_key ##1 s_gap_cycle;
  endsequence

  sequence s_tight_unlock;
    s_first_key ##1 s_second_key;
  endsequence

  chk_no_allow_start: assert property (@(posedge clk) disable iff (!rst_n)
    !write_allow |-> !start_write) else $error("write started without allow");
  chk_start_needs_key: assert property (@(posedge clk) disable iff (!rst_n)
    start_write |-> $past(unlock_state) == 2'h2) else $error("start without unlock");
  chk_key_then_start: assert property (@(posedge clk) disable iff (!rst_n)
    s_exact_unlock ##1 s_start_request |-> start_write) else $error("exact unlock refused");
  chk_tight_refused: assert property (@(posedge clk) disable iff (!rst_n)
    s_tight_unlock ##1 wr_ctrl |-> !start_write) else $error("unlock without gap taken");
  chk_wr_held: assert property (@(posedge clk) disable iff (!rst_n)
    write_start && !tmr_done |=> write_start) else $error("write start dropped");
  chk_done_sets: assert property (@(posedge clk) disable iff (!rst_n)
    tmr_done |=> write_done_flag && !write_start) else $error("done not flagged");
  chk_read_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    read_start |=> !read_start) else $error("read start held");
  chk_pwrup_block: assert property (@(posedge clk) disable iff (!rst_n)
    pwrup_hold |-> !start_write) else $error("write during power-up hold");
  chk_unlock_zero: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rd && reg_addr == nv_data_pkg::OFF_UNLOCK |=> reg_rdata == 8'h00)
    else $error("unlock read nonzero");
  chk_ctrl_upper: assert property (@(posedge clk) disable iff (!rst_n)
    reg_rdata[7:4] == 4'h0 || $past(reg_addr) != nv_data_pkg::OFF_CONTROL)
    else $error("control upper bits set");

  // Write start takes effect at once, timer running and erasing first
  chk_start_sets: assert property (@(posedge clk) disable iff (!rst_n)
    start_write |=> write_start && tmr_busy) else $error("start write not taken");
  chk_erase_first: assert property (@(posedge clk) disable iff (!rst_n)
    start_write |=> tmr_erase) else $error("write did not erase first");

  // Read request raises the read bit for one cycle
  chk_read_taken: assert property (@(posedge clk) disable iff (!rst_n)
    wr_ctrl && reg_wdata[nv_data_pkg::BIT_RD] && !write_start |=> read_start)
    else $error("read request lost");

  // State only software, power-on or a finished write may change; a cut write sets only the abort flag
  chk_abort_sets: assert property (@(posedge clk) disable iff (!por_n)
    !rst_n && write_start |=> write_abort_flag) else $error("cut write not flagged");
  chk_addr_kept: assert property (@(posedge clk) disable iff (!por_n)
    !(reg_wr && reg_addr == nv_data_pkg::OFF_ADDR) |=> $stable(byte_address_reg))
    else $error("address changed unasked");
  chk_data_kept: assert property (@(posedge clk) disable iff (!por_n)
    !(reg_wr && (reg_addr == nv_data_pkg::OFF_DATA || reg_addr == nv_data_pkg::OFF_CONTROL))
    |=> $stable(byte_data_reg)) else $error("data changed unasked");
  chk_allow_kept: assert property (@(posedge clk) disable iff (!por_n)
    !wr_ctrl |=> $stable(write_allow)) else $error("write allow changed by hardware");
  chk_done_sticky: assert property (@(posedge clk) disable iff (!por_n)
    write_done_flag && !(reg_wr && reg_addr == nv_data_pkg::OFF_FLAGS) |=> write_done_flag)
    else $error("done flag dropped by hardware");
endmodule : nv_data_ctrl

//--- sim/cpu_port.sv
`timescale 1ns/100ps
// Software side of the register port
module cpu_port (
  // Clock
  input wire logic clk,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // Quiet bus at time zero
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One access per edge; strobes hold until the next call, never set twice a step
  task automatic put(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : put
endmodule : cpu_port

//--- sim/testbench.sv
`timescale 1ns/100ps
// Self-checking bench for the data memory controller
module testbench;
  logic clk;
  logic rst_n;
  logic por_n;
  logic pwrup_timer_en;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic write_busy;
  logic write_done_flag;
  logic [7:0] exp_q[$];
  logic pend;
  logic [31:0] seed;
  logic [7:0] a;
  logic [7:0] d;
  int miscompares;
  int num_checks;

  // 200 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Short hold and write counts keep the run brief
  nv_data_ctrl #(.DEPTH(256), .PWRUP_CYCLES(20), .WRITE_CYCLES(8)) u_dut (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .pwrup_timer_en(pwrup_timer_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .write_busy(write_busy), .write_done_flag(write_done_flag));

  cpu_port u_cpu (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd));

  // Xorshift source, fixed start
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd

  task automatic idle(input int n);
    repeat (n) u_cpu.put(1'b0, 1'b0, 8'h5a, 8'ha5);
  endtask : idle

  task automatic wr(input logic [7:0] ra, input logic [7:0] v);
    u_cpu.put(1'b1, 1'b0, ra, v);
  endtask : wr

  // Read, noting the byte expected one cycle later
  task automatic rd(input logic [7:0] ra, input logic [7:0] e);
    exp_q.push_back(e);
    u_cpu.put(1'b0, 1'b1, ra, 8'h00);
  endtask : rd

  // Load, set allow bit en, unlock with g idle cycles, start
  task automatic ws(input logic [7:0] ad, input logic [7:0] v, input int g, input logic en);
    wr(nv_data_pkg::OFF_ADDR, ad);
    wr(nv_data_pkg::OFF_DATA, v);
    wr(nv_data_pkg::OFF_CONTROL, {5'h00, en, 2'h0});
    wr(nv_data_pkg::OFF_UNLOCK, nv_data_pkg::KEY_FIRST);
    idle(g);
    wr(nv_data_pkg::OFF_UNLOCK, nv_data_pkg::KEY_SECOND);
    idle(g);
    wr(nv_data_pkg::OFF_CONTROL, {5'h00, en, 2'h2});
    idle(1);
  endtask : ws

  // Busy lags a cycle, so let it rise before polling
  task automatic wait_done();
    idle(2);
    #1;
    pin(write_busy, 1'b1);
    for (int k = 0; k < 40 && write_busy !== 1'b0; k++)
    begin
      idle(1);
      #1;
    end
    pin(write_busy, 1'b0);
    pin(write_done_flag, 1'b1);
    idle(1);
  endtask : wait_done

  // Direct look at a status pin, counted like any other check
  task automatic pin(input logic got, input logic e);
    num_checks++;
    if (got !== e)
    begin
      miscompares++;
      $display("mismatch t=%0t got %h exp %h", $time, got, e);
    end
  endtask : pin

  task automatic chk(input logic [7:0] ad, input logic [7:0] e);
    wr(nv_data_pkg::OFF_ADDR, ad);
    wr(nv_data_pkg::OFF_CONTROL, 8'h05);
    rd(nv_data_pkg::OFF_DATA, e);
  endtask : chk

  task automatic test_done();
    if (miscompares == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // Compare each answer with the oldest note, mid-cycle when settled
  always @(negedge clk)
  begin
    if (pend)
    begin
      num_checks++;
      if (reg_rdata !== exp_q[0])
      begin
        miscompares++;
        $display("mismatch t=%0t got %h exp %h", $time, reg_rdata, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
    pend = reg_rd;
  end

  // Watchdog well beyond the roughly 140 cycles needed
  initial
  begin
    repeat (3000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial
  begin
    seed = 32'd23;
    miscompares = 0;
    num_checks = 0;
    pend = 1'b0;
    rst_n = 1'b0;
    por_n = 1'b0;
    pwrup_timer_en = 1'b1;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    ws(8'h10, 8'h3c, 1, 1'b1);
    rd(nv_data_pkg::OFF_CONTROL, 8'h04);
    rd(nv_data_pkg::OFF_UNLOCK, 8'h00);
    idle(25);
    a = rnd();
    d = rnd();
    ws(a, d, 1, 1'b1);
    rd(nv_data_pkg::OFF_CONTROL, 8'h06);
    wr(nv_data_pkg::OFF_CONTROL, 8'h00);
    rd(nv_data_pkg::OFF_CONTROL, 8'h02);
    wait_done();
    rd(nv_data_pkg::OFF_CONTROL, 8'h00);
    rd(nv_data_pkg::OFF_FLAGS, 8'h01);
    wr(nv_data_pkg::OFF_FLAGS, 8'h00);
    rd(nv_data_pkg::OFF_FLAGS, 8'h00);
    #1;
    pin(write_done_flag, 1'b0);
    ws(a ^ 8'h80, ~d, 1, 1'b1);
    wait_done();
    chk(a, d);
    rd(nv_data_pkg::OFF_CONTROL, 8'h04);
    rd(nv_data_pkg::OFF_DATA, d);
    chk(a ^ 8'h80, ~d);
    ws(a, 8'h00, 1, 1'b0);
    rd(nv_data_pkg::OFF_CONTROL, 8'h00);
    for (int g = 0; g < 3; g += 2)
    begin
      ws(a, 8'h00, g, 1'b1);
      rd(nv_data_pkg::OFF_CONTROL, 8'h04);
    end
    chk(a, d);
    ws(a, d ^ 8'h0f, 1, 1'b1);
    idle(2);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(nv_data_pkg::OFF_CONTROL, 8'h0c);
    rd(nv_data_pkg::OFF_ADDR, a);
    rd(nv_data_pkg::OFF_DATA, d ^ 8'h0f);
    idle(3);
    test_done();
  end
endmodule : testbench
